// ==== core/sar_adc_serial_readout.sv ====
// Contract
// - serial input high at strobe rise selects chip-select mode
// - serial input low at strobe rise selects daisy-chain mode
// - optional busy bit precedes result bits in chip-select mode only
// - conversion timed by internal clock, between minimum and maximum time
// - serial clock only shifts results; reads happen during acquisition
// - result is straight unsigned binary, sixteen bits
// - strobe rise: tri-state output, capture sample, start conversion
// - started conversion completes regardless of strobe level
// - strobe high at conversion end: no busy bit
// - conversion end enters acquisition and powers down
// - strobe fall releases output and drives result MSB
// - each serial clock fall shifts next lower bit out
// - each bit stays valid across both serial clock edges
// - output tri-states at sixteenth serial clock fall (seventeenth after a busy bit) or strobe rise
// - analog inputs disconnected during conversion, reconnected at end
`timescale 1ns/1ps
module sar_adc_serial_readout
    import sar_pkg::*;
#(
    parameter int CONV_LEN = sar_pkg::CONV_CYCLES,
    parameter int DEPTH    = sar_pkg::BUF_DEPTH
) (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            reset,
    // host pins
    input  wire logic                            convertStrobe,
    input  wire logic                            serialIn,
    input  wire logic                            serialClk,
    output logic                                 serialOut,
    output logic                                 serialOutEn_n,
    // analog core
    input  wire logic [sar_pkg::RESULT_BITS-1:0] sampleCode,
    output logic                                 trackEnable,
    output logic                                 powerDown,
    // status
    output logic                                 chipSelectMode,
    output logic                                 resultStall
);
    import sar_pkg::*;

    // pin synchronisers
    logic strobeMeta;
    logic strobeSync;
    logic strobeLast;
    logic sclkMeta;
    logic sclkSync;
    logic sclkLast;
    logic dinMeta;
    logic dinSync;

    logic strobeRise;
    logic strobeFall;
    logic sclkFall;

    // conversion group
    sar_phase_t                phase;
    sar_phase_t                next_phase;
    logic [CONV_COUNT_W-1:0]   convCount;
    logic [CONV_COUNT_W-1:0]   next_convCount;
    logic [RESULT_BITS-1:0]    convResult;
    logic [RESULT_BITS-1:0]    next_convResult;
    logic                      next_chipSelectMode;
    logic                      next_trackEnable;
    logic                      next_powerDown;
    logic                      next_resultStall;
    logic                      doneEvent;

    // readout group
    sar_read_t                 readState;
    sar_read_t                 next_readState;
    logic [RESULT_BITS-1:0]    shiftReg;
    logic [RESULT_BITS-1:0]    next_shiftReg;
    logic [BIT_COUNT_W-1:0]    bitCount;
    logic [BIT_COUNT_W-1:0]    next_bitCount;
    logic [RESULT_BITS-1:0]    latestResult;
    logic [RESULT_BITS-1:0]    next_latestResult;
    logic                      haveResult;
    logic                      next_haveResult;
    logic                      next_serialOut;
    logic                      next_serialOutEn_n;
    logic                      popResult;

    localparam logic [CONV_COUNT_W-1:0] CONV_LAST = CONV_COUNT_W'(CONV_LEN - 1);
    localparam logic [BIT_COUNT_W-1:0]  BITS_ALL  = BIT_COUNT_W'(RESULT_BITS);
    localparam logic [BIT_COUNT_W-1:0]  BIT_ONE   = BIT_COUNT_W'(1);

    function automatic logic msbOf(input logic [RESULT_BITS-1:0] w);
        msbOf = w[RESULT_BITS-1];
    endfunction : msbOf

    sar_buf_if #(.WIDTH(RESULT_BITS)) resultPath ();

    sar_buf #(
        .WIDTH (RESULT_BITS),
        .DEPTH (DEPTH)
    ) resultBuf (
        .clk   (clk),
        .reset (reset),
        .port  (resultPath.store)
    );

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            strobeMeta <= RST_PIN_LEVEL;
            strobeSync <= RST_PIN_LEVEL;
            strobeLast <= RST_PIN_LEVEL;
            sclkMeta   <= RST_PIN_LEVEL;
            sclkSync   <= RST_PIN_LEVEL;
            sclkLast   <= RST_PIN_LEVEL;
            dinMeta    <= RST_PIN_LEVEL;
            dinSync    <= RST_PIN_LEVEL;
        end else begin
            strobeMeta <= convertStrobe;
            strobeSync <= strobeMeta;
            strobeLast <= strobeSync;
            sclkMeta   <= serialClk;
            sclkSync   <= sclkMeta;
            sclkLast   <= sclkSync;
            dinMeta    <= serialIn;
            dinSync    <= dinMeta;
        end
    end

    assign strobeRise = strobeSync & ~strobeLast;
    assign strobeFall = ~strobeSync & strobeLast;
    // serial clock edges only matter for reading
    assign sclkFall   = ~sclkSync & sclkLast;

    // a finished word leaves only once the buffer takes it
    assign doneEvent  = (phase == SAR_DONE) && resultPath.inReady;

    assign resultPath.inValid  = (phase == SAR_DONE);
    assign resultPath.inData   = convResult;
    // never swap the word under an active shift
    assign resultPath.outReady = (readState != SAR_RD_DATA);
    assign popResult           = resultPath.outValid && resultPath.outReady;

    // conversion sequencing
    always_comb begin
        next_phase          = phase;
        next_convCount      = convCount;
        next_convResult     = convResult;
        next_chipSelectMode = chipSelectMode;
        next_trackEnable    = trackEnable;
        next_powerDown      = powerDown;
        next_resultStall    = 1'b0;
        case (phase)
            SAR_ACQ: begin
                if (strobeRise) begin
                    next_phase          = SAR_CONV;
                    next_convCount      = '0;
                    // level of serial input picks the mode
                    next_chipSelectMode = dinSync;
                    next_trackEnable    = 1'b0;
                    next_powerDown      = 1'b0;
                end
            end
            SAR_CONV: begin
                // strobe ignored here: a conversion cannot be aborted
                if (convCount == CONV_LAST) begin
                    next_phase      = SAR_DONE;
                    // straight binary, no offset or sign handling
                    next_convResult = sampleCode;
                end else begin
                    next_convCount = convCount + CONV_COUNT_W'(1);
                end
            end
            SAR_DONE: begin
                next_resultStall = ~resultPath.inReady;
                if (resultPath.inReady) begin
                    next_phase       = SAR_ACQ;
                    next_trackEnable = 1'b1;
                    next_powerDown   = 1'b1;
                end
            end
            default: begin
                next_phase       = SAR_ACQ;
                next_convCount   = '0;
                next_trackEnable = RST_TRACK;
                next_powerDown   = RST_POWERDOWN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            phase          <= SAR_ACQ;
            convCount      <= '0;
            convResult     <= '0;
            chipSelectMode <= RST_CS_MODE;
            trackEnable    <= RST_TRACK;
            powerDown      <= RST_POWERDOWN;
            resultStall    <= 1'b0;
        end else begin
            phase          <= next_phase;
            convCount      <= next_convCount;
            convResult     <= next_convResult;
            chipSelectMode <= next_chipSelectMode;
            trackEnable    <= next_trackEnable;
            powerDown      <= next_powerDown;
            resultStall    <= next_resultStall;
        end
    end

    // serial readout
    always_comb begin
        next_readState     = readState;
        next_shiftReg      = shiftReg;
        next_bitCount      = bitCount;
        next_latestResult  = latestResult;
        next_haveResult    = haveResult;
        next_serialOut     = serialOut;
        next_serialOutEn_n = serialOutEn_n;
        if (popResult) begin
            next_latestResult = resultPath.outData;
            next_haveResult   = 1'b1;
        end
        if (strobeRise && phase == SAR_ACQ) begin
            // new conversion: drop any read in flight
            next_readState     = SAR_RD_OFF;
            next_serialOutEn_n = 1'b1;
            next_bitCount      = '0;
        end else if (strobeRise) begin
            next_readState     = SAR_RD_OFF;
            next_serialOutEn_n = 1'b1;
        end else begin
            case (readState)
                SAR_RD_OFF: begin
                    if (doneEvent && chipSelectMode && !strobeSync) begin
                        // strobe high at the end suppresses this branch
                        next_readState     = SAR_RD_BUSY;
                        next_serialOut     = BUSY_LEVEL;
                        next_serialOutEn_n = 1'b0;
                        next_bitCount      = '0;
                    end else if (strobeFall && phase == SAR_ACQ && haveResult) begin
                        next_readState     = SAR_RD_DATA;
                        next_serialOut     = msbOf(latestResult);
                        next_shiftReg      = latestResult << 1;
                        next_serialOutEn_n = 1'b0;
                        next_bitCount      = BIT_ONE;
                    end
                end
                SAR_RD_BUSY: begin
                    if (sclkFall) begin
                        // busy bit ends, MSB follows on this fall
                        next_readState = SAR_RD_DATA;
                        next_serialOut = msbOf(popResult ? resultPath.outData : latestResult);
                        next_shiftReg  = (popResult ? resultPath.outData : latestResult) << 1;
                        next_bitCount  = BIT_ONE;
                    end
                end
                SAR_RD_DATA: begin
                    // bit changes only on falls, so it holds across the rise
                    if (sclkFall) begin
                        if (bitCount == BITS_ALL) begin
                            next_readState     = SAR_RD_OFF;
                            next_serialOutEn_n = 1'b1;
                        end else begin
                            next_serialOut = msbOf(shiftReg);
                            next_shiftReg  = shiftReg << 1;
                            next_bitCount  = bitCount + BIT_ONE;
                        end
                    end
                end
                default: begin
                    next_readState     = SAR_RD_OFF;
                    next_serialOutEn_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            readState     <= SAR_RD_OFF;
            shiftReg      <= '0;
            bitCount      <= '0;
            latestResult  <= '0;
            haveResult    <= 1'b0;
            serialOut     <= 1'b0;
            serialOutEn_n <= 1'b1;
        end else begin
            readState     <= next_readState;
            shiftReg      <= next_shiftReg;
            bitCount      <= next_bitCount;
            latestResult  <= next_latestResult;
            haveResult    <= next_haveResult;
            serialOut     <= next_serialOut;
            serialOutEn_n <= next_serialOutEn_n;
        end
    end
endmodule : sar_adc_serial_readout

// ==== core/sar_pkg.sv ====
package sar_pkg;

    // result word
    localparam int RESULT_BITS     = 16;
    localparam int BIT_COUNT_W     = 5;

    // timing, clock runs at 20 MHz
    localparam int CLK_PERIOD_NS   = 50;
    localparam int CONV_TIME_NS    = 1400;
    // conversion length rounds down so it never overruns the nominal time
    localparam int CONV_CYCLES_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int CONV_CYCLES     = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
    localparam int CONV_COUNT_W    = 12;

    // result buffer
    localparam int BUF_DEPTH       = 2;

    // reset values and busy-bit level
    localparam logic RST_PIN_LEVEL = 1'b1;
    localparam logic RST_TRACK     = 1'b1;
    localparam logic RST_POWERDOWN = 1'b1;
    localparam logic RST_CS_MODE   = 1'b1;
    localparam logic BUSY_LEVEL    = 1'b0;

    typedef enum logic [2:0] {
        SAR_ACQ  = 3'h1,
        SAR_CONV = 3'h2,
        SAR_DONE = 3'h4
    } sar_phase_t;

    typedef enum logic [2:0] {
        SAR_RD_OFF  = 3'h1,
        SAR_RD_BUSY = 3'h2,
        SAR_RD_DATA = 3'h4
    } sar_read_t;

endpackage : sar_pkg

// ==== core/sar_buf_if.sv ====
`timescale 1ns/1ps
interface sar_buf_if #(
    parameter int WIDTH = 16
);
    logic             inValid;
    logic             inReady;
    logic [WIDTH-1:0] inData;
    logic             outValid;
    logic             outReady;
    logic [WIDTH-1:0] outData;

    modport store (
        input  inValid,
        input  inData,
        input  outReady,
        output inReady,
        output outValid,
        output outData
    );

    modport client (
        output inValid,
        output inData,
        output outReady,
        input  inReady,
        input  outValid,
        input  outData
    );
endinterface : sar_buf_if

// ==== core/sar_buf.sv ====
`timescale 1ns/1ps
module sar_buf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic   clk,
    input wire logic   reset,
    // both sides of the buffer
    sar_buf_if.store   port
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [CW-1:0]    fill;
    logic [PW-1:0]    next_wrPtr;
    logic [PW-1:0]    next_rdPtr;
    logic [CW-1:0]    next_fill;
    logic             doPush;
    logic             doPop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : bump

    assign port.inReady  = (fill != CW'(DEPTH));
    assign port.outValid = (fill != '0);
    assign port.outData  = mem[rdPtr];
    assign doPush        = port.inValid & port.inReady;
    assign doPop         = port.outValid & port.outReady;

    always_comb begin
        next_wrPtr = doPush ? bump(wrPtr) : wrPtr;
        next_rdPtr = doPop ? bump(rdPtr) : rdPtr;
        next_fill  = fill;
        if (doPush && !doPop) begin
            next_fill = fill + CW'(1);
        end else if (doPop && !doPush) begin
            next_fill = fill - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
            fill  <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            fill  <= next_fill;
        end
    end

    // storage needs no reset, fill guards it
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr] <= port.inData;
        end
    end
endmodule : sar_buf

// ==== tb/sar_adc_chk.sv ====
`timescale 1ns/1ps
module sar_adc_chk
    import sar_pkg::*;
#(
    parameter int CONV_LEN = 28
) (
    // clock and reset
    input wire logic                            clk,
    input wire logic                            reset,
    // host pins
    input wire logic                            convertStrobe,
    input wire logic                            serialIn,
    input wire logic                            serialClk,
    input wire logic                            serialOut,
    input wire logic                            serialOutEn_n,
    // analog core
    input wire logic [sar_pkg::RESULT_BITS-1:0] sampleCode,
    input wire logic                            trackEnable,
    input wire logic                            powerDown,
    // status
    input wire logic                            chipSelectMode,
    input wire logic                            resultStall
);
    int lowCnt;
    int next_lowCnt;

    // counts conversion cycles; too long for a repetition operator
    always_comb next_lowCnt = trackEnable ? 0 : lowCnt + 1;
    always_ff @(posedge clk) begin
        if (reset) lowCnt <= 0;
        else lowCnt <= next_lowCnt;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    track_pd_a: assert property (trackEnable == powerDown)
        else $error("track and power-down disagree");
    conv_tri_a: assert property ($fell(trackEnable) |-> serialOutEn_n)
        else $error("output driven at conversion start");
    conv_len_a: assert property ($rose(trackEnable) |-> lowCnt >= CONV_LEN + 1)
        else $error("conversion too short");
    rise_tri_a: assert property ($rose(convertStrobe) |-> ##[1:5] serialOutEn_n)
        else $error("strobe rise left output driven");
    drive_acq_a: assert property (!serialOutEn_n |-> trackEnable && powerDown)
        else $error("output driven outside acquisition");
    drive_low_a: assert property ($fell(serialOutEn_n) |-> !convertStrobe)
        else $error("output enabled with strobe high");
    mode_hold_a: assert property (!$fell(trackEnable) |-> $stable(chipSelectMode))
        else $error("mode changed outside a start");
    stall_wait_a: assert property (resultStall |-> !trackEnable)
        else $error("acquisition while word waits");
    reset_idle_a: assert property ($past(reset) |-> serialOutEn_n && trackEnable && !resultStall)
        else $error("not idle after reset");

    cover property ($rose(trackEnable));
    cover property ($fell(serialOutEn_n) && !serialOut);
    cover property ($fell(trackEnable) && !chipSelectMode);
endmodule : sar_adc_chk

bind sar_adc_serial_readout sar_adc_chk #(.CONV_LEN(CONV_LEN)) chk_u (
    .clk(clk), .reset(reset), .convertStrobe(convertStrobe), .serialIn(serialIn),
    .serialClk(serialClk), .serialOut(serialOut), .serialOutEn_n(serialOutEn_n),
    .sampleCode(sampleCode), .trackEnable(trackEnable), .powerDown(powerDown),
    .chipSelectMode(chipSelectMode), .resultStall(resultStall)
);

// ==== tb/sar_host_model.sv ====
`timescale 1ns/1ps
module sar_host_model #(
    parameter int MAX_WAIT = 30
) (
    // pacing clock
    input wire logic clk,
    // pins toward the converter
    output logic     convertStrobe,
    output logic     serialIn,
    output logic     serialClk,
    input wire logic serialOut,
    input wire logic serialOutEn_n
);
    logic pinLevel;

    // pull-up holds the line high once the converter lets go
    assign pinLevel = serialOutEn_n ? 1'b1 : serialOut;

    initial begin
        convertStrobe = 1'b1;
        serialIn      = 1'b1;
        serialClk     = 1'b0;
    end

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // style 0 holds high, 1 dips mid-conversion, 2 stays low for a busy bit
    task convert(input logic csBit, input int style);
        if (convertStrobe) begin
            convertStrobe = 1'b0;
            cyc(4);
        end
        serialIn = csBit;
        cyc(4);
        convertStrobe = 1'b1;
        cyc(5);
        if (style == 1) begin
            convertStrobe = 1'b0;
            cyc(4);
            convertStrobe = 1'b1;
        end
        if (style == 2) convertStrobe = 1'b0;
        serialIn = 1'b1;
        cyc(MAX_WAIT);
    endtask : convert

    // samples just before each fall, where the bit has long settled
    task read(input int nBits, output logic [16:0] word);
        word = '0;
        convertStrobe = 1'b0;
        cyc(8);
        for (int i = 0; i < nBits; i++) begin
            serialClk = 1'b1;
            cyc(4);
            word = {word[15:0], pinLevel};
            serialClk = 1'b0;
            cyc(4);
        end
    endtask : read

    task raise_strobe;
        convertStrobe = 1'b1;
        cyc(1);
    endtask : raise_strobe
endmodule : sar_host_model

// ==== tb/sar_adc_serial_readout_tb_top.sv ====
`timescale 1ns/1ps
module sar_adc_serial_readout_tb_top;
    import sar_pkg::*;
    // short conversion keeps the run brief
    localparam int CONV = 12;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        convertStrobe, serialIn, serialClk, serialOut, serialOutEn_n;
    logic [15:0] sampleCode = 16'h0000;
    logic        trackEnable, powerDown, chipSelectMode, resultStall;
    logic [16:0] word;
    int          failures = 0;
    int          checks = 0;

    always #25 clk = ~clk;

    sar_adc_serial_readout #(.CONV_LEN(CONV), .DEPTH(sar_pkg::BUF_DEPTH)) dut_u (
        .clk(clk), .reset(reset), .convertStrobe(convertStrobe), .serialIn(serialIn),
        .serialClk(serialClk), .serialOut(serialOut), .serialOutEn_n(serialOutEn_n),
        .sampleCode(sampleCode), .trackEnable(trackEnable), .powerDown(powerDown),
        .chipSelectMode(chipSelectMode), .resultStall(resultStall)
    );

    sar_host_model #(.MAX_WAIT(CONV + 8)) host_u (
        .clk(clk), .convertStrobe(convertStrobe), .serialIn(serialIn),
        .serialClk(serialClk), .serialOut(serialOut), .serialOutEn_n(serialOutEn_n)
    );

    task test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task wait_idle;
        for (int i = 0; i < 200; i++) begin
            if (trackEnable === 1'b1) return;
            cyc(1);
        end
        failures++;
        test_done();
    endtask : wait_idle

    task test_reset;
        chk("idle", 17'({serialOutEn_n, trackEnable, powerDown, resultStall}), 17'h0000E);
        chk("mode", 17'(chipSelectMode), 17'h00001);
    endtask : test_reset

    task test_daisy;
        host_u.convert(1'b0, 0);
        chk("daisy", 17'(chipSelectMode), 17'h00000);
        wait_idle();
    endtask : test_daisy

    task test_plain;
        sampleCode = 16'hA5C3;
        host_u.convert(1'b1, 0);
        chk("select", 17'(chipSelectMode), 17'h00001);
        wait_idle();
        chk("acq", 17'({trackEnable, powerDown, resultStall}), 17'h00006);
        host_u.read(16, word);
        chk("word", word, 17'h0A5C3);
        cyc(4);
        chk("tri16", 17'(serialOutEn_n), 17'h00001);
    endtask : test_plain

    // two words without a read; only the newer one may come out
    task test_latest;
        sampleCode = 16'h8001;
        host_u.convert(1'b1, 1);
        wait_idle();
        sampleCode = 16'h7FFE;
        host_u.convert(1'b1, 1);
        wait_idle();
        host_u.read(8, word);
        chk("msb", word, 17'h0007F);
        host_u.raise_strobe();
        cyc(5);
        chk("abort", 17'(serialOutEn_n), 17'h00001);
        // that rise also started a conversion; the read must wait for it
        wait_idle();
        host_u.read(16, word);
        chk("reread", word, 17'h07FFE);
    endtask : test_latest

    task test_busy;
        sampleCode = 16'h1234;
        host_u.convert(1'b1, 2);
        wait_idle();
        host_u.read(17, word);
        chk("busy", word, 17'h01234);
        cyc(4);
        chk("tri17", 17'(serialOutEn_n), 17'h00001);
    endtask : test_busy

    initial begin
        cyc(16);
        reset = 1'b0;
        cyc(2);
        test_reset();
        test_daisy();
        test_plain();
        test_latest();
        test_busy();
        test_done();
    end
endmodule : sar_adc_serial_readout_tb_top
